// ==== src/scc_pkg.sv ====
/*
 * Package for the stepper chopper timing block: register map, field layout, reset values,
 * timing counts and the carrier structs shared by the design.
 * Assumes a 200 MHz system clock and a 32-bit APB register bus.
 */
package scc_pkg;

  localparam int unsigned SYS_CLK_MHZ = 200;
  localparam int unsigned RESET_DELAY_NS = 700;
  // The longest allowed time rounds down to whole cycles.
  localparam int unsigned RESET_DELAY_CYC = (RESET_DELAY_NS * SYS_CLK_MHZ) / 1000;

  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STAT_OFFSET = 12'h004;
  localparam logic [11:0] TIME_OFFSET = 12'h008;

  localparam int unsigned PROG_BITS = 6;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_CLRPROG_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  localparam int unsigned PROG_OPEN_BIT = 5;
  localparam int unsigned PROG_SLOW_BIT = 4;
  localparam int unsigned PROG_OLHALF_BIT = 3;
  localparam int unsigned PROG_RED_LSB = 0;
  localparam logic [5:0] PROG_RESET = 6'h00;

  localparam logic [15:0] PERIOD_RESET = 16'd999;
  localparam logic [15:0] TONMIN_RESET = 16'd99;

  typedef struct packed {
    logic open_loop;
    logic slow_rate;
    logic ol_half;
    logic [2:0] reduced_level;
  } scc_prog_s;

  typedef struct packed {
    logic chopping_switch;
    logic outputs_enabled;
    logic blanking;
    logic reduced_active;
  } scc_drive_s;

  typedef enum logic [1:0] {
    SCC_ST_RESET = 2'b00,
    SCC_ST_ON = 2'b01,
    SCC_ST_OFF = 2'b10
  } scc_chop_e;

endpackage

// ==== src/scc_top.sv ====
/*
 * Chopping timing and mode control for a unipolar stepper driver: oscillator period pacing,
 * blanking, closed and open loop on-time, phase-change restart, reset and program handling.
 * Assumes all pin inputs are synchronous to sys_clk and an APB master on the register bus.
 */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Fast chopping rate uses one oscillator period per chopping period.
// - Closed-loop on-time never shorter than the oscillator discharge interval.
// - Blanking window of minimum on-time masks sense at each period start.
// - Open-loop on-time is 75% or 50% of minimum on-time, unregulated.
// - Closed-loop on-time starts at oscillator pulse, ends at sense trip.
// - Phase change restarts the oscillator period and turns the switch on at once.
// - Low oscillator pin clears program and disables outputs within 700 ns.
// - Supply threshold crossing produces an internal reset, up and down.
// - Closed loop slow rate starts on-time on every second oscillator cycle.
// - Mode may be reprogrammed any number of times during operation.
// - Level input low gives full current; high gives programmed reduced level in closed loop, full current in open loop.
// - Program data is shifted in only in programming mode and latched after it ends, with level high.

module scc_top
  import scc_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_pin_low,
  input wire logic supply_low,
  input wire logic phase_change,
  input wire logic sense_trip,
  input wire logic program_mode,
  input wire logic program_clock,
  input wire logic level_and_program_data_input,
  input wire logic open_loop_program_data_input,
  output scc_pkg::scc_drive_s drive,
  output logic [2:0] current_level
);
  import scc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0] period_r, period_nxt;
  logic [CNT_W-1:0] tonmin_r, tonmin_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic access;
  logic clr_prog_req;
  scc_prog_s prog_r, prog_nxt;
  scc_chop_e state_r, state_nxt;
  logic [15:0] status_word;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == CTRL_OFFSET) || (a == STAT_OFFSET) || (a == TIME_OFFSET);
  endfunction

  assign access = psel && penable;
  // Single-cycle access phase: the slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = rdata_r;
  assign pslverr = err_r;
  assign clr_prog_req = access && pwrite && (paddr == CTRL_OFFSET) && pwdata[CTRL_CLRPROG_BIT];
  assign status_word = {8'h00, state_r, prog_r};

  always_comb begin
    ctrl_nxt = ctrl_r;
    period_nxt = period_r;
    tonmin_nxt = tonmin_r;
    err_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (psel && !penable) begin
      err_nxt = !addr_known(paddr);
      unique case (paddr)
        CTRL_OFFSET: rdata_nxt = {30'h0, 1'b0, ctrl_r[CTRL_ENABLE_BIT]};
        STAT_OFFSET: rdata_nxt = {16'h0000, status_word};
        TIME_OFFSET: rdata_nxt = {tonmin_r, period_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        CTRL_OFFSET: ctrl_nxt = {31'h0, pwdata[CTRL_ENABLE_BIT]};
        TIME_OFFSET: begin
          period_nxt = pwdata[CNT_W-1:0];
          tonmin_nxt = pwdata[16 +: CNT_W];
        end
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
      period_r <= PERIOD_RESET;
      tonmin_r <= TONMIN_RESET;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      period_r <= period_nxt;
      tonmin_r <= tonmin_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program shift register and reset sources.

  logic [PROG_BITS-1:0] shift_r, shift_nxt;
  logic clk_d_r, clk_d_nxt;
  logic [2:0] disc_cnt_r, disc_cnt_nxt;
  logic pin_reset;
  logic soft_reset;

  // Oscillator-pin reset and supply reset take effect at the next clock edge, well inside the delay budget.
  assign pin_reset = osc_pin_low;
  assign soft_reset = pin_reset || supply_low || clr_prog_req;

  always_comb begin
    shift_nxt = shift_r;
    prog_nxt = prog_r;
    clk_d_nxt = program_clock;
    disc_cnt_nxt = disc_cnt_r;
    if (soft_reset) begin
      shift_nxt = PROG_RESET;
      prog_nxt = PROG_RESET;
      disc_cnt_nxt = 3'd0;
    end else if (program_mode) begin
      // Data shifts in only in programming mode, so other drivers on the line are ignored.
      if (program_clock && !clk_d_r) begin
        shift_nxt = {shift_r[PROG_BITS-2:0], open_loop_program_data_input};
        disc_cnt_nxt = disc_cnt_r + 3'd1;
      end
    end else if (clk_d_r && !program_clock) begin
      disc_cnt_nxt = 3'd0;
    end
    // A full word is taken on leaving programming mode, only while the level line is high.
    if (!soft_reset && !program_mode && level_and_program_data_input && disc_cnt_r >= 3'd6) begin
      prog_nxt = shift_r;
      disc_cnt_nxt = 3'd0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= PROG_RESET;
      prog_r <= PROG_RESET;
      clk_d_r <= 1'b0;
      disc_cnt_r <= 3'd0;
    end else begin
      shift_r <= shift_nxt;
      prog_r <= prog_nxt;
      clk_d_r <= clk_d_nxt;
      disc_cnt_r <= disc_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator and chopping state.

  logic [CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
  logic [CNT_W-1:0] on_cnt_r, on_cnt_nxt;
  logic odd_r, odd_nxt;
  logic osc_pulse;
  logic start_period;
  logic enabled;
  logic [CNT_W-1:0] on_len;
  logic sw_r, sw_nxt;
  logic blank_r, blank_nxt;

  assign enabled = ctrl_r[CTRL_ENABLE_BIT] && !pin_reset && !supply_low;
  assign osc_pulse = (osc_cnt_r == period_r);
  // Fast rate and open loop: each oscillator cycle is a chopping period; closed-loop slow rate skips every other one.
  assign start_period = phase_change ||
      (osc_pulse && (prog_r.open_loop || !prog_r.slow_rate || odd_r));
  // Open-loop on-time is three quarters or one half of the minimum on-time.
  assign on_len = prog_r.ol_half ? (tonmin_r >> 1) :
      (tonmin_r - (tonmin_r >> 2));

  always_comb begin
    osc_cnt_nxt = osc_pulse ? '0 : osc_cnt_r + 1'b1;
    odd_nxt = osc_pulse ? !odd_r : odd_r;
    on_cnt_nxt = (on_cnt_r == {CNT_W{1'b1}}) ? on_cnt_r : on_cnt_r + 1'b1;
    state_nxt = state_r;
    if (phase_change) begin
      osc_cnt_nxt = '0;
      odd_nxt = 1'b1;
    end
    if (!enabled) begin
      state_nxt = SCC_ST_RESET;
    end else if (start_period) begin
      state_nxt = SCC_ST_ON;
      on_cnt_nxt = '0;
    end else begin
      unique case (state_r)
        SCC_ST_RESET: state_nxt = SCC_ST_RESET;
        SCC_ST_ON: begin
          if (prog_r.open_loop) begin
            if (on_cnt_r + 1'b1 >= on_len) state_nxt = SCC_ST_OFF;
          end else if (sense_trip && on_cnt_r + 1'b1 >= tonmin_r) begin
            state_nxt = SCC_ST_OFF;
          end
        end
        SCC_ST_OFF: state_nxt = SCC_ST_OFF;
        default: state_nxt = SCC_ST_RESET;
      endcase
    end
    sw_nxt = (state_nxt == SCC_ST_ON);
    blank_nxt = (state_nxt == SCC_ST_ON) && (on_cnt_nxt < tonmin_r);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= '0;
      on_cnt_r <= '0;
      odd_r <= 1'b0;
      state_r <= SCC_ST_RESET;
      sw_r <= 1'b0;
      blank_r <= 1'b0;
    end else begin
      osc_cnt_r <= osc_cnt_nxt;
      on_cnt_r <= on_cnt_nxt;
      odd_r <= odd_nxt;
      state_r <= state_nxt;
      sw_r <= sw_nxt;
      blank_r <= blank_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drive outputs.

  logic red_r, red_nxt;
  logic [2:0] lvl_r, lvl_nxt;

  always_comb begin
    red_nxt = level_and_program_data_input && !prog_r.open_loop;
    lvl_nxt = red_nxt ? prog_r.reduced_level : 3'h7;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      red_r <= 1'b0;
      lvl_r <= 3'h7;
    end else begin
      red_r <= red_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign drive.chopping_switch = sw_r;
  assign drive.outputs_enabled = (state_r != SCC_ST_RESET);
  assign drive.blanking = blank_r;
  assign drive.reduced_active = red_r;
  assign current_level = lvl_r;

endmodule
`default_nettype wire

// ==== verif/scc_checker.sv ====
/* Port-level checker for the chopper timing block.
   Assumes it is bound to every scc_top instance and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module scc_checker
  import scc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic osc_pin_low,
  input wire logic supply_low,
  input wire logic phase_change,
  input wire logic level_and_program_data_input,
  input wire scc_pkg::scc_drive_s drive,
  input wire logic [2:0] current_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic run;
  assign run = drive.outputs_enabled && !osc_pin_low && !supply_low;
  property p_phase; phase_change && run |=> drive.chopping_switch; endproperty
  a_phase: assert property (p_phase) else $error("switch not on after phase change");
  property p_blank; phase_change && run |-> ##[1:2] drive.blanking; endproperty
  a_blank: assert property (p_blank) else $error("no blanking after restart");
  property p_osc; $rose(osc_pin_low) |-> ##[1:2] !drive.outputs_enabled; endproperty
  a_osc: assert property (p_osc) else $error("outputs on after osc pin low");
  property p_sup; $rose(supply_low) |-> ##[1:2] !drive.outputs_enabled; endproperty
  a_sup: assert property (p_sup) else $error("outputs on after supply low");
  property p_off; !drive.outputs_enabled |-> !drive.chopping_switch; endproperty
  a_off: assert property (p_off) else $error("switch on while disabled");
  property p_nom; !level_and_program_data_input |=> current_level == 3'h7; endproperty
  a_nom: assert property (p_nom) else $error("level low but not nominal");
  property p_red; !level_and_program_data_input |=> !drive.reduced_active; endproperty
  a_red: assert property (p_red) else $error("reduced while level low");
  property p_hold; $fell(drive.chopping_switch) && !phase_change |=> !drive.chopping_switch;
  endproperty
  a_hold: assert property (p_hold) else $error("switch back on in same period");
  property p_err; psel && penable && paddr > 12'h008 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
endmodule
bind scc_top scc_checker chk_i (.sys_clk, .resetn, .psel, .penable, .paddr, .pslverr,
  .osc_pin_low, .supply_low, .phase_change, .level_and_program_data_input, .drive,
  .current_level);
`default_nettype wire

// ==== verif/scc_mcu.sv ====
/* Controller model driving phase, level and serial program pins.
   Assumes the bench calls its tasks; all pins change just after sys_clk rises. */
`timescale 1ns/1ps
`default_nettype none
module scc_mcu (
  input wire logic sys_clk,
  output logic phase_change,
  output logic lvl,
  output logic pmode,
  output logic pclk,
  output logic pdata
);
  initial begin
    {phase_change, lvl, pmode, pclk, pdata} = 5'h00;
  end
  // Level stays high through the whole load, since only then is the word taken.
  task automatic load(input logic [5:0] w, input logic m);
    int i;
    @(posedge sys_clk); pmode <= m; lvl <= 1'b1;
    for (i = 5; i >= 0; i--) begin
      @(posedge sys_clk); pdata <= w[i]; pclk <= 1'b0;
      @(posedge sys_clk); pclk <= 1'b1;
    end
    @(posedge sys_clk); pclk <= 1'b0; pmode <= 1'b0; pdata <= ~w[0];
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic level(input logic v);
    @(posedge sys_clk); lvl <= v;
  endtask
  task automatic pulse;
    @(posedge sys_clk); phase_change <= 1'b1;
    @(posedge sys_clk); phase_change <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/stepper_chopper_timing_control_tb_top.sv ====
/* Self-checking bench for the chopper timing block.
   Assumes the controller model and checker files are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module stepper_chopper_timing_control_tb_top;
  import scc_pkg::*;
  logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, sup = 0, sense = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, ph, lvl, pm, pc, pd;
  scc_drive_s drive;
  logic [2:0] current_level;
  int fails = 0, n_checks = 0, cyc = 0, on_len, per, i;
  always #2.5 sys_clk = ~sys_clk;
  scc_top dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pin_low(osc), .supply_low(sup), .phase_change(ph),
    .sense_trip(sense), .program_mode(pm), .program_clock(pc),
    .level_and_program_data_input(lvl), .open_loop_program_data_input(pd),
    .drive(drive), .current_level(current_level));
  scc_mcu mcu (.sys_clk(sys_clk), .phase_change(ph), .lvl(lvl), .pmode(pm), .pclk(pc),
    .pdata(pd));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk); penable <= 1;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Measures one on-time and the spacing between two switch-on edges.
  task automatic meas;
    for (i = 0; i < 200 && drive.chopping_switch !== 1'b0; i++) @(negedge sys_clk);
    for (i = 0; i < 200 && drive.chopping_switch !== 1'b1; i++) @(negedge sys_clk);
    on_len = 0;
    per = 0;
    while (drive.chopping_switch === 1'b1 && per < 200) begin @(negedge sys_clk); on_len++; per++; end
    while (drive.chopping_switch !== 1'b1 && per < 200) begin @(negedge sys_clk); per++; end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1; // osc pin stays released through power-up
    repeat (3) @(posedge sys_clk);
    apb(0, CTRL_OFFSET, 0); chk(rd, CTRL_RESET);
    apb(0, TIME_OFFSET, 0); chk(rd, {TONMIN_RESET, PERIOD_RESET});
    apb(0, STAT_OFFSET, 0); chk(32'(rd[5:0]), 32'(PROG_RESET));
    apb(1, 12'h010, 32'h5); chk(32'(err), 1);
    apb(0, 12'h010, 0); chk(rd, 0);
    apb(1, TIME_OFFSET, 32'h0008_0013);
    apb(0, TIME_OFFSET, 0); chk(rd, 32'h0008_0013);
    mcu.load(6'h05, 1);
    apb(0, STAT_OFFSET, 0); chk(32'(rd[5:0]), 5);
    chk(32'(current_level), 5);
    mcu.load(6'h21, 0);
    apb(0, STAT_OFFSET, 0); chk(32'(rd[5:0]), 5);
    mcu.level(0);
    repeat (2) @(negedge sys_clk);
    chk(32'(current_level), 7);
    sense <= 1;
    meas; chk(per, 20);
    chk(32'(on_len >= 8), 1);
    for (i = 0; i < 40 && drive.chopping_switch !== 1'b0; i++) @(posedge sys_clk);
    sense <= 0;
    repeat (4) @(negedge sys_clk);
    chk(32'(drive.chopping_switch), 0);
    mcu.pulse;
    @(negedge sys_clk); chk(32'(drive.chopping_switch), 1);
    sense <= 1;
    mcu.load(6'h10, 1);
    mcu.level(0);
    meas; chk(per, 40);
    sense <= 0;
    mcu.load(6'h20, 1);
    meas; chk(on_len, 6);
    mcu.load(6'h28, 1);
    meas; chk(on_len, 4);
    osc <= 1;
    repeat (2) @(negedge sys_clk);
    chk(32'(drive.outputs_enabled), 0);
    apb(0, STAT_OFFSET, 0); chk(32'(rd[5:0]), 0);
    osc <= 0;
    mcu.load(6'h05, 1);
    sup <= 1;
    repeat (2) @(negedge sys_clk);
    chk(32'(drive.outputs_enabled), 0);
    apb(0, STAT_OFFSET, 0); chk(32'(rd[5:0]), 0);
    close_out;
  end
endmodule
`default_nettype wire
